// ===== src/vfcr_pkg.sv
package vfcr_pkg;

  // Bus address of this bank on the two-wire link; the value is arbitrary.
  localparam logic [6:0] VFCR_DEV_ADDR = 7'h4C;

  localparam logic [7:0] VFCR_ADDR_FIRST    = 8'h01;
  localparam logic [7:0] VFCR_ADDR_DIV_HIGH = 8'h01;
  localparam logic [7:0] VFCR_ADDR_DIV_LOW  = 8'h02;
  localparam logic [7:0] VFCR_ADDR_CLKGEN   = 8'h03;
  localparam logic [7:0] VFCR_ADDR_PHASE    = 8'h04;
  localparam logic [7:0] VFCR_ADDR_GAIN0    = 8'h05;
  localparam logic [7:0] VFCR_ADDR_ADJUST0  = 8'h08;
  localparam logic [7:0] VFCR_ADDR_BRIGHT0  = 8'h09;
  localparam logic [7:0] VFCR_ADDR_SYNCW    = 8'h0E;
  localparam logic [7:0] VFCR_ADDR_ENTER    = 8'h0F;
  localparam logic [7:0] VFCR_ADDR_EXIT     = 8'h10;
  localparam logic [7:0] VFCR_ADDR_SOURCE   = 8'h11;
  localparam logic [7:0] VFCR_ADDR_LAST     = 8'h11;
  localparam int         VFCR_REG_COUNT     = 17;
  localparam int         VFCR_CHANNELS      = 3;
  localparam int         VFCR_CH_STRIDE     = 2;

  localparam int VFCR_IDX_DIV_HIGH = 0;
  localparam int VFCR_IDX_DIV_LOW  = 1;
  localparam int VFCR_IDX_CLKGEN   = 2;
  localparam int VFCR_IDX_PHASE    = 3;
  localparam int VFCR_IDX_GAIN0    = 4;
  localparam int VFCR_IDX_ADJUST0  = 7;
  localparam int VFCR_IDX_BRIGHT0  = 8;
  localparam int VFCR_IDX_SYNCW    = 13;
  localparam int VFCR_IDX_ENTER    = 14;
  localparam int VFCR_IDX_EXIT     = 15;
  localparam int VFCR_IDX_SOURCE   = 16;

  localparam int VFCR_NIB_MSB   = 7;
  localparam int VFCR_NIB_LSB   = 4;
  localparam int VFCR_BAND_MSB  = 7;
  localparam int VFCR_BAND_LSB  = 6;
  localparam int VFCR_LOOP_MSB  = 5;
  localparam int VFCR_LOOP_LSB  = 3;
  localparam int VFCR_EXT_BIT   = 2;
  localparam int VFCR_PHASE_MSB = 7;
  localparam int VFCR_PHASE_LSB = 3;
  localparam int VFCR_SLICE_MSB = 7;
  localparam int VFCR_SLICE_LSB = 2;
  localparam int VFCR_HSRC_BIT  = 7;
  localparam int VFCR_HOVR_BIT  = 6;
  localparam int VFCR_VSRC_BIT  = 5;
  localparam int VFCR_VOVR_BIT  = 4;
  localparam int VFCR_CHAN_BIT  = 3;
  localparam int VFCR_COVR_BIT  = 2;

  localparam logic [11:0] VFCR_RST_RATIO    = 12'h69D;
  localparam logic [7:0]  VFCR_RST_DIV_HIGH = 8'h69;
  localparam logic [7:0]  VFCR_RST_DIV_LOW  = 8'hD0;
  localparam logic [7:0]  VFCR_RST_CLKGEN   = 8'h48;
  localparam logic [7:0]  VFCR_RST_PHASE    = 8'h80;
  localparam logic [7:0]  VFCR_RST_GAIN     = 8'h80;
  localparam logic [7:0]  VFCR_RST_ADJUST   = 8'h00;
  localparam logic [7:0]  VFCR_RST_BRIGHT   = 8'h80;
  localparam logic [7:0]  VFCR_RST_SYNCW    = 8'h20;
  localparam logic [7:0]  VFCR_RST_SLICE    = 8'h40;
  localparam logic [7:0]  VFCR_RST_SOURCE   = 8'h00;
  localparam logic [8:0]  VFCR_OFFSET_MID   = 9'h080;
  localparam logic [3:0]  VFCR_BYTE_BITS    = 4'h8;

  typedef enum logic [6:0] {
    VFCR_S_IDLE = 7'h01,
    VFCR_S_DEV  = 7'h02,
    VFCR_S_SUB  = 7'h04,
    VFCR_S_WR   = 7'h08,
    VFCR_S_ACK  = 7'h10,
    VFCR_S_RD   = 7'h20,
    VFCR_S_MACK = 7'h40
  } vfcr_state_t;

  function automatic logic [7:0] vfcr_reset(input logic [7:0] addr);
    case (addr)
      VFCR_ADDR_DIV_HIGH:                     return VFCR_RST_DIV_HIGH;
      VFCR_ADDR_DIV_LOW:                      return VFCR_RST_DIV_LOW;
      VFCR_ADDR_CLKGEN:                       return VFCR_RST_CLKGEN;
      VFCR_ADDR_PHASE:                        return VFCR_RST_PHASE;
      8'h05, 8'h06, 8'h07:                    return VFCR_RST_GAIN;
      8'h08, 8'h0A, 8'h0C:                    return VFCR_RST_ADJUST;
      8'h09, 8'h0B, 8'h0D:                    return VFCR_RST_BRIGHT;
      VFCR_ADDR_SYNCW:                        return VFCR_RST_SYNCW;
      VFCR_ADDR_ENTER, VFCR_ADDR_EXIT:        return VFCR_RST_SLICE;
      default:                                return VFCR_RST_SOURCE;
    endcase
  endfunction

  function automatic logic [7:0] vfcr_mask(input logic [7:0] addr);
    case (addr)
      VFCR_ADDR_DIV_LOW:                                 return 8'hF0;
      VFCR_ADDR_CLKGEN, VFCR_ADDR_ENTER, VFCR_ADDR_EXIT: return 8'hFC;
      VFCR_ADDR_SOURCE:                                  return 8'hFC;
      VFCR_ADDR_PHASE:                                   return 8'hF8;
      default:                                           return 8'hFF;
    endcase
  endfunction

endpackage

// ===== src/vfcr_regs.sv
// Notes on behaviour
// RULE1 - Divider low register bits 7..4 hold the ratio's four low bits.
// RULE2 - After reset the divide ratio is 1693; high register reads 0x69.
// RULE3 - Active ratio updates only on a low register write, never on high alone.
// RULE4 - Two-bit band field picks generator range; resets to 01.
// RULE5 - Three-bit loop current field, eight current steps, resets to 001.
// RULE6 - External clock bit picks the clock pin, ratio ignored; resets 0.
// RULE7 - Five-bit sampling phase, 32 steps per pixel, resets to 16.
// RULE8 - Per-channel eight-bit gain, zero smallest range, resets to 0x80.
// RULE9 - Per-channel signed clamp target byte, clamp code under feedback, resets zero.
// RULE10 - One step of clamp target adds exactly one code of offset.
// RULE11 - Per-channel brightness: absolute or relative offset; resets to 0x80.
// RULE12 - Clamp feedback enable input decides how offsets are interpreted; the code only copies it to clamp_feedback_active, offset_level ignores it.
// RULE13 - Composite sync width register sets maximum pulse width; resets 0x20.
// RULE14 - Host keeps slicer enter threshold below exit; both reset to 0x10.
// RULE15 - Horizontal source bit picks sync input or green sync when overridden.
// RULE16 - Vertical source bit picks sync input or green extracted when overridden.
// RULE17 - Channel select bit picks input 0 or 1 when overridden.
// RULE18 - Override bits zero choose automatically, one use manual bit; reset 0.
// RULE19 - Undefined bits read zero and ignore writes.
module vfcr_regs
  import vfcr_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        scl_pin,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  input  wire logic        clamp_feedback_enable,
  input  wire logic        auto_hsync_source,
  input  wire logic        auto_vsync_source,
  input  wire logic        auto_channel_sel,
  output logic [11:0]      pixel_divide_ratio,
  output logic [1:0]       frequency_band_select,
  output logic [2:0]       loop_current,
  output logic             external_clock_enable,
  output logic [4:0]       sampling_phase,
  output logic [7:0]       channel_gain [VFCR_CHANNELS],
  output logic [7:0]       clamp_target [VFCR_CHANNELS],
  output logic [7:0]       brightness [VFCR_CHANNELS],
  output logic [8:0]       offset_level [VFCR_CHANNELS],
  output logic             clamp_feedback_active,
  output logic [7:0]       composite_sync_width,
  output logic [5:0]       green_slicer_enter,
  output logic [5:0]       green_slicer_exit,
  output logic             hsync_source_sel,
  output logic             vsync_source_sel,
  output logic             input_channel_sel
);

  logic [7:0]  cfg [VFCR_REG_COUNT];
  logic [7:0]  next_cfg [VFCR_REG_COUNT];
  logic        wr_en, in_range_wr, in_range_rd;
  logic [7:0]  wr_addr, wr_data, rd_addr, rd_data;
  logic [7:0]  wr_index, rd_index;
  logic [11:0] next_ratio;
  logic        next_hsel, next_vsel, next_csel;

  vfcr_serial_slave u_link (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .scl_pin (scl_pin),
    .sda_in  (sda_in),
    .sda_oe  (sda_oe),
    .wr_en   (wr_en),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .rd_addr (rd_addr),
    .rd_data (rd_data)
  );

  assign in_range_wr = wr_addr >= VFCR_ADDR_FIRST && wr_addr <= VFCR_ADDR_LAST;
  assign in_range_rd = rd_addr >= VFCR_ADDR_FIRST && rd_addr <= VFCR_ADDR_LAST;
  assign wr_index    = wr_addr - VFCR_ADDR_FIRST;
  assign rd_index    = rd_addr - VFCR_ADDR_FIRST;
  // Unmapped addresses read zero so a host scan never sees stale data.
  assign rd_data     = in_range_rd ? cfg[rd_index[4:0]] : 8'h00;

  always_comb begin
    for (int i = 0; i < VFCR_REG_COUNT; i++) begin
      next_cfg[i] = cfg[i];
      // RULE2 power-up defaults
      if (sys_rst) begin
        next_cfg[i] = vfcr_reset(VFCR_ADDR_FIRST + 8'(i));
      end
    end
    // RULE19 undefined bits masked
    if (!sys_rst && wr_en && in_range_wr) begin
      next_cfg[wr_index[4:0]] = wr_data & vfcr_mask(wr_addr);
    end
  end

  always_comb begin
    next_ratio = pixel_divide_ratio;
    // RULE3 low write commits ratio
    if (sys_rst) begin
      next_ratio = VFCR_RST_RATIO;
    end else if (wr_en && wr_addr == VFCR_ADDR_DIV_LOW) begin
      // RULE1 low nibble from upper bits
      next_ratio = {cfg[VFCR_IDX_DIV_HIGH], wr_data[VFCR_NIB_MSB:VFCR_NIB_LSB]};
    end
  end

  always_comb begin
    // RULE18 override picks manual
    // RULE15 horizontal source choice
    next_hsel = cfg[VFCR_IDX_SOURCE][VFCR_HOVR_BIT] ? cfg[VFCR_IDX_SOURCE][VFCR_HSRC_BIT]
                                                     : auto_hsync_source;
    // RULE16 vertical source choice
    next_vsel = cfg[VFCR_IDX_SOURCE][VFCR_VOVR_BIT] ? cfg[VFCR_IDX_SOURCE][VFCR_VSRC_BIT]
                                                     : auto_vsync_source;
    // RULE17 input channel choice
    next_csel = cfg[VFCR_IDX_SOURCE][VFCR_COVR_BIT] ? cfg[VFCR_IDX_SOURCE][VFCR_CHAN_BIT]
                                                     : auto_channel_sel;
    if (sys_rst) begin
      next_hsel = 1'b0;
      next_vsel = 1'b0;
      next_csel = 1'b0;
    end
  end

  // Field outputs follow next_cfg so they move in the same cycle as the register.
  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < VFCR_REG_COUNT; i++) begin
      cfg[i] <= next_cfg[i];
    end
    sda_out               <= 1'b0;
    pixel_divide_ratio    <= next_ratio;
    // RULE4 band field
    frequency_band_select <= next_cfg[VFCR_IDX_CLKGEN][VFCR_BAND_MSB:VFCR_BAND_LSB];
    // RULE5 loop current field
    loop_current          <= next_cfg[VFCR_IDX_CLKGEN][VFCR_LOOP_MSB:VFCR_LOOP_LSB];
    // RULE6 external clock select
    external_clock_enable <= next_cfg[VFCR_IDX_CLKGEN][VFCR_EXT_BIT];
    // RULE7 sampling phase field
    sampling_phase        <= next_cfg[VFCR_IDX_PHASE][VFCR_PHASE_MSB:VFCR_PHASE_LSB];
    // RULE13 sync width field
    composite_sync_width  <= next_cfg[VFCR_IDX_SYNCW];
    // RULE14 slicer thresholds
    green_slicer_enter    <= next_cfg[VFCR_IDX_ENTER][VFCR_SLICE_MSB:VFCR_SLICE_LSB];
    green_slicer_exit     <= next_cfg[VFCR_IDX_EXIT][VFCR_SLICE_MSB:VFCR_SLICE_LSB];
    // RULE12 feedback mode flag
    clamp_feedback_active <= sys_rst ? 1'b0 : clamp_feedback_enable;
    hsync_source_sel      <= next_hsel;
    vsync_source_sel      <= next_vsel;
    input_channel_sel     <= next_csel;
  end

  for (genvar c = 0; c < VFCR_CHANNELS; c++) begin : g_chan
    logic [8:0] next_level;
    // RULE10 one code per step
    // RULE11 brightness relative to midpoint
    assign next_level = {next_cfg[VFCR_IDX_ADJUST0 + VFCR_CH_STRIDE * c][7],
                         next_cfg[VFCR_IDX_ADJUST0 + VFCR_CH_STRIDE * c]}
                      + {1'b0, next_cfg[VFCR_IDX_BRIGHT0 + VFCR_CH_STRIDE * c]}
                      - VFCR_OFFSET_MID;
    always_ff @(posedge clk_sys) begin
      // RULE8 gain per channel
      channel_gain[c] <= next_cfg[VFCR_IDX_GAIN0 + c];
      // RULE9 signed clamp target
      clamp_target[c] <= next_cfg[VFCR_IDX_ADJUST0 + VFCR_CH_STRIDE * c];
      brightness[c]   <= next_cfg[VFCR_IDX_BRIGHT0 + VFCR_CH_STRIDE * c];
      offset_level[c] <= next_level;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  a_low_nibble_match: assert property ( // RULE1
    pixel_divide_ratio[3:0] == cfg[VFCR_IDX_DIV_LOW][VFCR_NIB_MSB:VFCR_NIB_LSB])
    else $error("Ratio low nibble differs from low register.");
  a_reset_ratio: assert property (disable iff (1'b0) // RULE2
    sys_rst |=> pixel_divide_ratio == VFCR_RST_RATIO && cfg[VFCR_IDX_DIV_HIGH] == 8'h69)
    else $error("Divide ratio not at power-up value.");
  a_low_write_commit: assert property ( // RULE3
    wr_en && wr_addr == VFCR_ADDR_DIV_LOW |=>
      pixel_divide_ratio == {$past(cfg[VFCR_IDX_DIV_HIGH]), $past(wr_data[7:4])})
    else $error("Low write did not commit the ratio.");
  a_high_write_hold: assert property ( // RULE3
    wr_en && wr_addr == VFCR_ADDR_DIV_HIGH |=> $stable(pixel_divide_ratio))
    else $error("High write alone changed the ratio.");
  a_band_reset: assert property (disable iff (1'b0) // RULE4
    sys_rst |=> frequency_band_select == 2'h1)
    else $error("Band field not at reset value.");
  a_loop_reset: assert property (disable iff (1'b0) // RULE5
    sys_rst |=> loop_current == 3'h1)
    else $error("Loop current not at reset value.");
  a_ext_clock_follow: assert property ( // RULE6
    wr_en && wr_addr == VFCR_ADDR_CLKGEN |=> external_clock_enable == $past(wr_data[2]))
    else $error("External clock bit did not follow write.");
  a_phase_reset: assert property (disable iff (1'b0) // RULE7
    sys_rst |=> sampling_phase == 5'h10)
    else $error("Phase not at reset value.");
  a_gain_reset: assert property (disable iff (1'b0) // RULE8
    sys_rst |=> channel_gain[1] == 8'h80)
    else $error("Gain not at reset value.");
  a_target_reset: assert property (disable iff (1'b0) // RULE9
    sys_rst |=> clamp_target[2] == 8'h00 && brightness[2] == 8'h80)
    else $error("Offset registers not at reset value.");
  a_offset_step: assert property ( // RULE10
    $changed(clamp_target[0]) && $stable(brightness[0]) |->
      offset_level[0] - $past(offset_level[0]) == {clamp_target[0][7], clamp_target[0]}
      - {$past(clamp_target[0][7]), $past(clamp_target[0])})
    else $error("Offset step is not one code per step.");
  a_feedback_follow: assert property ( // RULE12
    !$past(sys_rst) |-> clamp_feedback_active == $past(clamp_feedback_enable))
    else $error("Feedback flag did not follow input.");
  a_sync_width_reset: assert property (disable iff (1'b0) // RULE13
    sys_rst |=> composite_sync_width == 8'h20 && green_slicer_exit == 6'h10)
    else $error("Sync registers not at reset value.");
  a_hsync_select: assert property ( // RULE15
    !$past(sys_rst) && !$past(cfg[VFCR_IDX_SOURCE][VFCR_HOVR_BIT]) |->
      hsync_source_sel == $past(auto_hsync_source))
    else $error("Horizontal source ignored automatic choice.");
  a_vsync_select: assert property ( // RULE16
    !$past(sys_rst) && $past(cfg[VFCR_IDX_SOURCE][VFCR_VOVR_BIT]) |->
      vsync_source_sel == $past(cfg[VFCR_IDX_SOURCE][VFCR_VSRC_BIT]))
    else $error("Vertical source ignored manual bit.");
  a_channel_select: assert property ( // RULE17
    !$past(sys_rst) && $past(cfg[VFCR_IDX_SOURCE][VFCR_COVR_BIT]) |->
      input_channel_sel == $past(cfg[VFCR_IDX_SOURCE][VFCR_CHAN_BIT]))
    else $error("Channel select ignored manual bit.");
  a_override_reset: assert property (disable iff (1'b0) // RULE18
    sys_rst |=> cfg[VFCR_IDX_SOURCE] == 8'h00 && !hsync_source_sel)
    else $error("Override bits not cleared by reset.");
  a_reserved_zero: assert property ( // RULE19
    cfg[VFCR_IDX_DIV_LOW][3:0] == 4'h0 && cfg[VFCR_IDX_PHASE][2:0] == 3'h0
      && cfg[VFCR_IDX_SOURCE][1:0] == 2'h0)
    else $error("Undefined bits hold a nonzero value.");
  a_gain_follow: assert property ( // RULE8
    wr_en && wr_addr == VFCR_ADDR_GAIN0 |=> channel_gain[0] == $past(wr_data))
    else $error("Gain did not follow write.");
  a_phase_follow: assert property ( // RULE7
    wr_en && wr_addr == VFCR_ADDR_PHASE |=>
      sampling_phase == $past(wr_data[VFCR_PHASE_MSB:VFCR_PHASE_LSB]))
    else $error("Phase did not follow write.");
  a_band_follow: assert property ( // RULE4 RULE5
    wr_en && wr_addr == VFCR_ADDR_CLKGEN |=>
      {frequency_band_select, loop_current} == $past(wr_data[VFCR_BAND_MSB:VFCR_LOOP_LSB]))
    else $error("Clock generator fields did not follow write.");
  a_sync_width_follow: assert property ( // RULE13
    wr_en && wr_addr == VFCR_ADDR_SYNCW |=> composite_sync_width == $past(wr_data))
    else $error("Sync width did not follow write.");

  cov_low_write: cover property (wr_en && wr_addr == VFCR_ADDR_DIV_LOW);
  cov_high_then_low: cover property (wr_en && wr_addr == VFCR_ADDR_DIV_HIGH ##[1:400]
    wr_en && wr_addr == VFCR_ADDR_DIV_LOW);
  cov_override_on: cover property (cfg[VFCR_IDX_SOURCE][VFCR_HOVR_BIT]);

endmodule

// ===== src/vfcr_serial_slave.sv
module vfcr_serial_slave
  import vfcr_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  input  wire logic       scl_pin,
  input  wire logic       sda_in,
  output logic            sda_oe,
  output logic            wr_en,
  output logic [7:0]      wr_addr,
  output logic [7:0]      wr_data,
  output logic [7:0]      rd_addr,
  input  wire logic [7:0] rd_data
);

  logic        scl_meta, scl_s, scl_d, sda_meta, sda_s, sda_d;
  vfcr_state_t state, next_state, after, next_after;
  logic [3:0]  cnt, next_cnt;
  logic [7:0]  shreg, next_shreg, tx, next_tx, next_rd_addr;
  logic [7:0]  next_wr_addr, next_wr_data;
  logic        nack, next_nack, next_sda_oe, next_wr_en;
  logic        scl_rise, scl_fall, start_seen, stop_seen;

  assign scl_rise   = scl_s & ~scl_d;
  assign scl_fall   = ~scl_s & scl_d;
  assign start_seen = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_seen  = scl_s & scl_d & ~sda_d & sda_s;

  always_comb begin
    next_state   = state;
    next_after   = after;
    next_cnt     = cnt;
    next_shreg   = shreg;
    next_tx      = tx;
    next_rd_addr = rd_addr;
    next_nack    = nack;
    next_sda_oe  = sda_oe;
    next_wr_en   = 1'b0;
    next_wr_addr = wr_addr;
    next_wr_data = wr_data;
    if (stop_seen) begin
      next_state  = VFCR_S_IDLE;
      next_sda_oe = 1'b0;
    end else if (start_seen) begin
      // A repeated start keeps the pointer so a read can follow a subaddress write.
      next_state  = VFCR_S_DEV;
      next_cnt    = 4'h0;
      next_sda_oe = 1'b0;
    end else begin
      case (state)
        VFCR_S_IDLE: begin
        end
        VFCR_S_DEV, VFCR_S_SUB, VFCR_S_WR: begin
          if (scl_rise) begin
            next_shreg = {shreg[6:0], sda_s};
            next_cnt   = cnt + 4'h1;
          end else if (scl_fall && cnt == VFCR_BYTE_BITS) begin
            next_cnt    = 4'h0;
            next_sda_oe = 1'b1;
            next_state  = VFCR_S_ACK;
            if (state == VFCR_S_DEV) begin
              next_after = shreg[0] ? VFCR_S_RD : VFCR_S_SUB;
              if (shreg[7:1] != VFCR_DEV_ADDR) begin
                next_sda_oe = 1'b0;
                next_state  = VFCR_S_IDLE;
              end
            end else if (state == VFCR_S_SUB) begin
              next_rd_addr = shreg;
              next_after   = VFCR_S_WR;
            end else begin
              next_wr_en   = 1'b1;
              next_wr_addr = rd_addr;
              next_wr_data = shreg;
              next_rd_addr = rd_addr + 8'h01;
              next_after   = VFCR_S_WR;
            end
          end
        end
        VFCR_S_ACK: begin
          if (scl_fall) begin
            next_state  = after;
            next_sda_oe = 1'b0;
            if (after == VFCR_S_RD) begin
              next_tx     = rd_data;
              next_sda_oe = ~rd_data[7];
              next_cnt    = 4'h0;
            end
          end
        end
        VFCR_S_RD: begin
          if (scl_rise) begin
            next_cnt = cnt + 4'h1;
          end else if (scl_fall) begin
            if (cnt == VFCR_BYTE_BITS) begin
              next_sda_oe  = 1'b0;
              next_rd_addr = rd_addr + 8'h01;
              next_state   = VFCR_S_MACK;
            end else begin
              next_tx     = {tx[6:0], 1'b0};
              next_sda_oe = ~tx[6];
            end
          end
        end
        VFCR_S_MACK: begin
          if (scl_rise) begin
            next_nack = sda_s;
          end else if (scl_fall) begin
            next_state = VFCR_S_IDLE;
            if (!nack) begin
              next_tx     = rd_data;
              next_sda_oe = ~rd_data[7];
              next_cnt    = 4'h0;
              next_state  = VFCR_S_RD;
            end
          end
        end
        default: begin
          next_state  = VFCR_S_IDLE;
          next_sda_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    scl_meta <= scl_pin;
    scl_s    <= scl_meta;
    scl_d    <= scl_s;
    sda_meta <= sda_in;
    sda_s    <= sda_meta;
    sda_d    <= sda_s;
    if (sys_rst) begin
      state   <= VFCR_S_IDLE;
      after   <= VFCR_S_IDLE;
      cnt     <= 4'h0;
      shreg   <= 8'h00;
      tx      <= 8'h00;
      rd_addr <= 8'h00;
      nack    <= 1'b0;
      sda_oe  <= 1'b0;
      wr_en   <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 8'h00;
    end else begin
      state   <= next_state;
      after   <= next_after;
      cnt     <= next_cnt;
      shreg   <= next_shreg;
      tx      <= next_tx;
      rd_addr <= next_rd_addr;
      nack    <= next_nack;
      sda_oe  <= next_sda_oe;
      wr_en   <= next_wr_en;
      wr_addr <= next_wr_addr;
      wr_data <= next_wr_data;
    end
  end

  cov_read_byte: cover property (@(posedge clk_sys) state == VFCR_S_MACK && scl_fall && !nack);
  cov_master_nack: cover property (@(posedge clk_sys) state == VFCR_S_MACK && scl_fall && nack);

endmodule

// ===== verification/vfcr_host_model.sv
module vfcr_host_model
  import vfcr_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic sda_wire,
  output logic      scl_pin,
  output logic      sda_drv
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl_pin = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic q();
    repeat (5) @(posedge clk_sys);
  endtask
  // Data moves a quarter period after the clock falls, past the device's hold.
  task automatic bit_io(input logic b, output logic r);
    q();
    sda_drv <= b;
    q();
    scl_pin <= 1'b1;
    q();
    q();
    r = sda_wire;
    scl_pin <= 1'b0;
  endtask
  task automatic xfer(input logic [7:0] d, input logic ak, output logic [7:0] rd,
                      output logic nak);
    for (int i = 7; i >= 0; i--) bit_io(d[i], rd[i]);
    bit_io(ak, nak);
  endtask
  task automatic start();
    q();
    sda_drv <= 1'b1;
    q();
    scl_pin <= 1'b1;
    q();
    sda_drv <= 1'b0;
    q();
    scl_pin <= 1'b0;
  endtask
  task automatic stop();
    q();
    sda_drv <= 1'b0;
    q();
    scl_pin <= 1'b1;
    q();
    sda_drv <= 1'b1;
    q();
  endtask
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d, output logic nak);
    logic [7:0] x;
    logic       k0, k1, k2;
    start();
    xfer({VFCR_DEV_ADDR, 1'b0}, 1'b1, x, k0);
    xfer(a, 1'b1, x, k1);
    xfer(d, 1'b1, x, k2);
    stop();
    nak = k0 | k1 | k2;
  endtask
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic nak);
    logic [7:0] x;
    logic       k0, k1, k2, k3;
    start();
    xfer({VFCR_DEV_ADDR, 1'b0}, 1'b1, x, k0);
    xfer(a, 1'b1, x, k1);
    start();
    xfer({VFCR_DEV_ADDR, 1'b1}, 1'b1, x, k2);
    xfer(8'hFF, 1'b1, d, k3);
    stop();
    nak = k0 | k1 | k2;
  endtask
endmodule

// ===== verification/video_frontend_config_regs_tb.sv
module video_frontend_config_regs_tb
  import vfcr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, sys_rst, scl_pin, sda_drv, sda_oe, cfb, cfa, ah, av, ac, ext_en, hs, vs, ch;
  logic [11:0] ratio;
  logic [1:0]  band;
  logic [2:0]  loop_cur;
  logic [4:0]  phase;
  logic [7:0]  gain [3], tgt [3], bri [3], csw, d;
  logic [8:0]  lvl [3];
  logic [5:0]  ent, ex;
  logic        so, nk;
  logic [7:0]  rst_tab [17] = '{8'h69, 8'hD0, 8'h48, 8'h80, 8'h80, 8'h80, 8'h80, 8'h00,
                               8'h80, 8'h00, 8'h80, 8'h00, 8'h80, 8'h20, 8'h40, 8'h40, 8'h00};
  int fails, n_tests;
  // The wire is pulled up; either party only pulls it low.
  wire sda_wire = sda_drv & ~sda_oe;
  vfcr_host_model host (.clk_sys(clk_sys), .sda_wire(sda_wire), .scl_pin(scl_pin),
                        .sda_drv(sda_drv));
  vfcr_regs uut (.clk_sys(clk_sys), .sys_rst(sys_rst), .scl_pin(scl_pin), .sda_in(sda_wire),
    .sda_out(so), .sda_oe(sda_oe), .clamp_feedback_enable(cfb), .auto_hsync_source(ah),
    .auto_vsync_source(av), .auto_channel_sel(ac), .pixel_divide_ratio(ratio),
    .frequency_band_select(band), .loop_current(loop_cur), .external_clock_enable(ext_en),
    .sampling_phase(phase), .channel_gain(gain), .clamp_target(tgt), .brightness(bri),
    .offset_level(lvl), .clamp_feedback_active(cfa), .composite_sync_width(csw),
    .green_slicer_enter(ent), .green_slicer_exit(ex), .hsync_source_sel(hs),
    .vsync_source_sel(vs), .input_channel_sel(ch));
  always #5 clk_sys = ~clk_sys;
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    logic n;
    host.write_reg(a, v, n);
    chk(n, 1'b0);
  endtask
  task automatic rd(input logic [7:0] a);
    logic n;
    host.read_reg(a, d, n);
    chk(n, 1'b0);
  endtask
  function automatic logic [7:0] msk(input logic [7:0] a);
    if (a == 8'h02) return 8'hF0;
    if (a == 8'h04) return 8'hF8;
    if (a == 8'h03 || a == 8'h0F || a == 8'h10 || a == 8'h11) return 8'hFC;
    return 8'hFF;
  endfunction
  task automatic src(input logic [7:0] v, input logic au, input logic e);
    wr(8'h11, v);
    @(posedge clk_sys);
    {ah, av, ac} <= {3{au}};
    repeat (3) @(posedge clk_sys);
    chk({hs, vs, ch}, {3{e}});
  endtask
  initial begin
    repeat (100000) @(posedge clk_sys);
    fails++;
    $display("ERROR %0t run did not finish", $time);
    complete_run();
  end
  initial begin
    {clk_sys, sys_rst, cfb, ah, av, ac, fails, n_tests} = {2'b01, 4'h0, 64'h0};
    repeat (6) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    chk(ratio, 12'h69D);
    chk({band, loop_cur, ext_en}, 6'h12);
    chk(phase, 5'h10);
    for (logic [7:0] a = 8'h01; a <= 8'h11; a++) begin
      rd(a);
      chk(d, rst_tab[a-1]);
    end
    rd(8'h12);
    chk(d, 8'h00);
    $display("reset test done");
    // Enter is kept strictly below exit while every other field goes to all ones.
    for (logic [7:0] a = 8'h01; a <= 8'h11; a++) begin
      wr(a, (a == 8'h0F) ? 8'h17 : 8'hFF);
      rd(a);
      chk(d, ((a == 8'h0F) ? 8'h17 : 8'hFF) & msk(a));
    end
    chk(ratio, 12'hFFF);
    chk({band, loop_cur, ext_en, phase}, 11'h7FF);
    chk({ent, ex}, 12'h17F);
    chk({gain[2], csw}, 16'hFFFF);
    chk({tgt[0], bri[2]}, 16'hFFFF);
    chk({gain[0], tgt[2]}, 16'hFFFF);
    $display("field test done");
    wr(8'h01, 8'h12);
    chk(ratio, 12'hFFF);
    wr(8'h02, 8'h30);
    chk(ratio, 12'h123);
    $display("divider test done");
    src(8'h00, 1'b1, 1'b1);
    src(8'hA8, 1'b0, 1'b0);
    src(8'h54, 1'b1, 1'b0);
    src(8'hFC, 1'b0, 1'b1);
    $display("source test done");
    for (int c = 0; c < 3; c++) begin
      wr(8'h08 + 8'(2 * c), 8'h80);
      wr(8'h09 + 8'(2 * c), 8'h80);
      chk(lvl[c], 9'h180);
      wr(8'h08 + 8'(2 * c), 8'h81);
      chk(lvl[c], 9'h181);
      cfb <= 1'b1;
      repeat (3) @(posedge clk_sys);
      chk({cfa, lvl[c]}, 10'h381);
      cfb <= 1'b0;
    end
    $display("offset test done");
    host.start();
    host.xfer({VFCR_DEV_ADDR ^ 7'h01, 1'b0}, 1'b1, d, nk);
    host.stop();
    chk({nk, sda_wire, so}, 3'h6);
    $display("address test done");
    complete_run();
  end
endmodule
